// ==== shared/e3_rx_pkg.sv ====
// Constants for the E3 receive payload output and receive interrupt block.
// Assumes an 8-bit register port and a 50 MHz core clock.
package e3_rx_pkg;
	// Register offsets
	localparam logic [7:0] BLOCK_IRQ_ENABLE_ADDR = 8'h04;
	localparam logic [7:0] RX_CFG_STATUS_2_ADDR  = 8'h11;
	localparam logic [7:0] RX_IRQ_ENABLE_1_ADDR  = 8'h12;
	localparam logic [7:0] RX_OUT_CONFIG_ADDR    = 8'h13;
	localparam logic [7:0] RX_IRQ_STATUS_1_ADDR  = 8'h14;
	localparam logic [7:0] RX_IRQ_ENABLE_2_ADDR  = 8'h15;
	localparam logic [7:0] RX_IRQ_STATUS_2_ADDR  = 8'h16;
	// Field positions
	localparam int RX_BLOCK_EN_BIT = 7;
	localparam int LOS_STATE_BIT   = 4;
	localparam int LOS_IRQ_BIT     = 1;
	localparam int NIBBLE_MODE_BIT = 0;
	// Writable masks and reset values
	localparam logic [7:0] BLOCK_IRQ_ENABLE_MASK = 8'h83;
	localparam logic [7:0] SRC1_MASK             = 8'h1F;
	localparam logic [7:0] SRC2_MASK             = 8'h7F;
	localparam logic [7:0] REG_RESET             = 8'h00;
	// Timing: link bit period and core period, in ns
	localparam int LINE_CLK_NS   = 160;
	localparam int CORE_CLK_NS   = 20;
	localparam int BIT_CYCLES    = LINE_CLK_NS / CORE_CLK_NS;
	localparam int SER_HIGH_CYC  = BIT_CYCLES / 2;
	localparam int NIB_HIGH_CYC  = BIT_CYCLES;
	// Loss of signal thresholds, in line bits
	localparam int LOS_ZERO_RUN  = 32;
	localparam int LOS_GOOD_RUN  = 32;
	localparam int LOS_BAD_ZEROS = 4;
	localparam int NIBBLE_BITS   = 4;
endpackage : e3_rx_pkg

// ==== src/e3_los_detect.sv ====
// Loss of signal detector working on recovered line bits.
// Assumes one i_bit_tick per line bit, on the core clock.
`timescale 1ns/1ps
module e3_los_detect
	import e3_rx_pkg::*;
#(
	parameter int CNT_W = 6
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	// Line bits
	input  wire logic i_bit_tick,
	input  wire logic i_bit_zero,
	// Detector state
	output logic      o_los
);
	logic [CNT_W-1:0] zero_run_q;
	logic [CNT_W-1:0] good_run_q;
	logic             los_q;

	// Zero run length, saturating so a dead line stays declared
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			zero_run_q <= '0;
		end else if (i_bit_tick) begin
			if (!i_bit_zero) begin
				zero_run_q <= '0;
			end else if (zero_run_q != CNT_W'(LOS_ZERO_RUN)) begin
				zero_run_q <= zero_run_q + 1'b1;
			end
		end
	end

	// Bits since the last run of four zeros
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			good_run_q <= '0;
		end else if (i_bit_tick) begin
			if (i_bit_zero && zero_run_q >= CNT_W'(LOS_BAD_ZEROS - 1)) begin
				good_run_q <= '0;
			end else if (good_run_q != CNT_W'(LOS_GOOD_RUN)) begin
				good_run_q <= good_run_q + 1'b1;
			end
		end
	end

	// Declare on a long zero run, clear on a clean stretch
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			los_q <= 1'b0;
		end else if (zero_run_q == CNT_W'(LOS_ZERO_RUN)) begin
			los_q <= 1'b1; // R16
		end else if (good_run_q == CNT_W'(LOS_GOOD_RUN)) begin
			los_q <= 1'b0; // R17
		end
	end

	assign o_los = los_q;
endmodule : e3_los_detect

// ==== src/e3_rx_out_irq.sv ====
// Receive payload output port (serial or nibble) and receive interrupts.
// Assumes the framer feeds one payload bit per line bit on the core clock,
// and that rails and line clock come from outside the core clock domain.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps

// How it works
// R1: serial data changes with payload clock rise
// R2: far end samples bit and markers together
// R3: frame marker one bit with first bit
// R4: overhead marker high on overhead bits
// R5: far end discards overhead-marked bits
// R6: nibble bus updated at payload clock rise
// R7: nibble clock pulses 1060 times per frame
// R8: nibble clock high about a quarter period
// R9: frame marker one nibble with first nibble
// R10: far end samples nibble and marker together
// R11: receive section has twelve interrupt sources
// R12: request needs source and block enables
// R13: block enable bit 7 at 0x04
// R14: loss change interrupts on declare and clear
// R15: declare loss while loss input high
// R16: declare loss after 32 zero bits
// R17: clear on input low or clean 32 bits
// R18: loss interrupt enable bit 1 at 0x12
// R19: loss change sets status, drives request low
// R20: loss state readable at 0x11 bit 4
// R21: zero bit means neither rail high
module e3_rx_out_irq
	import e3_rx_pkg::*;
#(
	parameter int HIGH_W = 5
) (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	// Register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wr_data,
	input  wire logic       i_wr_en,
	input  wire logic       i_rd_en,
	output logic      [7:0] o_rd_data,
	// Framer side, core clock domain
	input  wire logic       i_rx_bit_valid,
	input  wire logic       i_rx_bit,
	input  wire logic       i_rx_bit_overhead,
	input  wire logic       i_rx_bit_first,
	input  wire logic [4:0] i_cond_change,
	input  wire logic [6:0] i_event,
	input  wire logic [2:0] i_cond_state,
	// Line interface pins
	input  wire logic       i_line_clk,
	input  wire logic       i_line_positive_rail_in,
	input  wire logic       i_line_negative_rail_in,
	input  wire logic       i_line_sig_loss_in,
	// Terminal equipment side
	output logic            o_rx_payload_clock,
	output logic            o_rx_serial_payload_out,
	output logic      [3:0] o_rx_payload_nibble,
	output logic            o_rx_frame_start_marker,
	output logic            o_rx_overhead_marker,
	// Host interrupt
	output logic            o_irq_n
);
	// Pin synchronisers
	logic [1:0] line_clk_sync_q;
	logic [1:0] pos_sync_q;
	logic [1:0] neg_sync_q;
	logic [1:0] loss_in_sync_q;
	logic       line_clk_prev_q;
	logic       bit_tick;
	logic       bit_zero;
	logic       det_los;
	logic       sig_loss_state;
	logic       sig_loss_prev_q;
	logic       los_change;
	// Registers
	logic [7:0] block_irq_enable_q;
	logic [7:0] rx_irq_enable_1_q;
	logic [7:0] rx_irq_enable_2_q;
	logic [7:0] rx_irq_status_1_q;
	logic [7:0] rx_irq_status_2_q;
	logic       lof_algo_q;
	logic       nibble_mode_q;
	logic [7:0] rd_data_q;
	logic [4:0] src1_event;
	logic       rd_status_1;
	logic       rd_status_2;
	// Payload output
	logic       pclk_q;
	logic [HIGH_W-1:0] high_cnt_q;
	logic       ser_q;
	logic [3:0] nib_q;
	logic [3:0] nib_shift_q;
	logic [1:0] nib_cnt_q;
	logic       frame_q;
	logic       ovh_q;
	logic       sof_pend_q;
	logic       payload_bit;
	logic       nib_done;
	logic       out_update;

	// Two-stage synchronisers; only the second stage is read below.
	// They run through reset, so a pin already high at release gives no false edge
	always_ff @(posedge i_clk) begin
		line_clk_sync_q <= {line_clk_sync_q[0], i_line_clk};
		pos_sync_q      <= {pos_sync_q[0], i_line_positive_rail_in};
		neg_sync_q      <= {neg_sync_q[0], i_line_negative_rail_in};
		loss_in_sync_q  <= {loss_in_sync_q[0], i_line_sig_loss_in};
	end

	// Line clock edge finder, fed from the second stage only
	always_ff @(posedge i_clk) begin
		line_clk_prev_q <= line_clk_sync_q[1];
	end

	// Rails are sampled on the same delayed edge, so they stay aligned
	assign bit_tick = line_clk_sync_q[1] & ~line_clk_prev_q;
	assign bit_zero = ~pos_sync_q[1] & ~neg_sync_q[1]; // R21

	e3_los_detect #(
		.CNT_W (6)
	) u_los_detect (
		.i_clk      (i_clk),
		.i_sys_rst  (i_sys_rst),
		.i_bit_tick (bit_tick),
		.i_bit_zero (bit_zero),
		.o_los      (det_los)
	);

	// Either the line interface pin or the zero-run detector holds loss
	assign sig_loss_state = loss_in_sync_q[1] | det_los; // R15 R17

	// Change of loss state, in both directions
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			sig_loss_prev_q <= 1'b0;
		end else begin
			sig_loss_prev_q <= sig_loss_state;
		end
	end

	assign los_change = sig_loss_state ^ sig_loss_prev_q; // R14

	// Events for status register 1; loss change replaces the framer's bit
	always_comb begin
		src1_event = i_cond_change;
		src1_event[LOS_IRQ_BIT] = los_change;
	end

	assign rd_status_1 = i_rd_en && (i_addr == RX_IRQ_STATUS_1_ADDR);
	assign rd_status_2 = i_rd_en && (i_addr == RX_IRQ_STATUS_2_ADDR);

	// Writable control registers
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			block_irq_enable_q <= REG_RESET;
			rx_irq_enable_1_q  <= REG_RESET;
			rx_irq_enable_2_q  <= REG_RESET;
			lof_algo_q         <= 1'b0;
			nibble_mode_q      <= 1'b0;
		end else if (i_wr_en) begin
			unique case (i_addr)
				BLOCK_IRQ_ENABLE_ADDR: begin
					block_irq_enable_q <= i_wr_data & BLOCK_IRQ_ENABLE_MASK; // R13
				end
				RX_IRQ_ENABLE_1_ADDR: begin
					rx_irq_enable_1_q <= i_wr_data & SRC1_MASK; // R18
				end
				RX_IRQ_ENABLE_2_ADDR: begin
					rx_irq_enable_2_q <= i_wr_data & SRC2_MASK;
				end
				RX_CFG_STATUS_2_ADDR: begin
					lof_algo_q <= i_wr_data[7];
				end
				RX_OUT_CONFIG_ADDR: begin
					nibble_mode_q <= i_wr_data[NIBBLE_MODE_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// Sticky status: enabled events set, a read clears, a set wins
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rx_irq_status_1_q <= REG_RESET;
		end else begin
			rx_irq_status_1_q <= ((rd_status_1 ? 8'h00 : rx_irq_status_1_q)
				| ({3'h0, src1_event} & rx_irq_enable_1_q)) & SRC1_MASK; // R11 R19
		end
	end

	// Second status group for the event-style sources
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rx_irq_status_2_q <= REG_RESET;
		end else begin
			rx_irq_status_2_q <= ((rd_status_2 ? 8'h00 : rx_irq_status_2_q)
				| ({1'b0, i_event} & rx_irq_enable_2_q)) & SRC2_MASK; // R11
		end
	end

	// Request needs a pending source and the receive block enable
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_irq_n <= 1'b1;
		end else begin
			o_irq_n <= ~(block_irq_enable_q[RX_BLOCK_EN_BIT]
				& (|rx_irq_status_1_q | |rx_irq_status_2_q)); // R12 R19
		end
	end

	// Read data appears one cycle after the strobe, zero otherwise
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rd_data_q <= 8'h00;
		end else if (i_rd_en) begin
			unique case (i_addr)
				BLOCK_IRQ_ENABLE_ADDR: rd_data_q <= block_irq_enable_q;
				RX_CFG_STATUS_2_ADDR: begin
					rd_data_q <= {lof_algo_q, i_cond_state[2:1], sig_loss_state, // R20
						i_cond_state[0], 3'h0};
				end
				RX_IRQ_ENABLE_1_ADDR: rd_data_q <= rx_irq_enable_1_q;
				RX_OUT_CONFIG_ADDR:   rd_data_q <= {7'h00, nibble_mode_q};
				RX_IRQ_STATUS_1_ADDR: rd_data_q <= rx_irq_status_1_q;
				RX_IRQ_ENABLE_2_ADDR: rd_data_q <= rx_irq_enable_2_q;
				RX_IRQ_STATUS_2_ADDR: rd_data_q <= rx_irq_status_2_q;
				default:              rd_data_q <= 8'h00;
			endcase
		end else begin
			rd_data_q <= 8'h00;
		end
	end

	assign o_rd_data = rd_data_q;

	// Payload bits exclude overhead; a nibble completes on its fourth bit
	assign payload_bit = i_rx_bit_valid & ~i_rx_bit_overhead;
	assign nib_done    = payload_bit && (nib_cnt_q == 2'(NIBBLE_BITS - 1) || i_rx_bit_first);
	assign out_update  = nibble_mode_q ? (payload_bit && !i_rx_bit_first
		&& nib_cnt_q == 2'(NIBBLE_BITS - 1)) : i_rx_bit_valid;

	// Nibble assembler; a frame's first bit restarts alignment
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			nib_shift_q <= 4'h0;
			nib_cnt_q   <= 2'h0;
		end else if (i_rx_bit_valid && i_rx_bit_first) begin
			nib_shift_q <= {3'h0, i_rx_bit};
			nib_cnt_q   <= i_rx_bit_overhead ? 2'h0 : 2'h1;
		end else if (payload_bit) begin
			nib_shift_q <= {nib_shift_q[2:0], i_rx_bit};
			nib_cnt_q   <= nib_done ? 2'h0 : nib_cnt_q + 2'h1;
		end
	end

	// First nibble of a frame carries the start marker
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			sof_pend_q <= 1'b0;
		end else if (i_rx_bit_valid && i_rx_bit_first) begin
			sof_pend_q <= 1'b1;
		end else if (out_update && nibble_mode_q) begin
			sof_pend_q <= 1'b0;
		end
	end

	// Output data and markers, changed only as the payload clock rises
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ser_q   <= 1'b0;
			nib_q   <= 4'h0;
			frame_q <= 1'b0;
			ovh_q   <= 1'b0;
		end else if (out_update) begin
			if (nibble_mode_q) begin
				nib_q   <= {nib_shift_q[2:0], i_rx_bit}; // R6
				frame_q <= sof_pend_q; // R9
				ovh_q   <= 1'b0;
			end else begin
				ser_q   <= i_rx_bit; // R1
				frame_q <= i_rx_bit_first; // R3
				ovh_q   <= i_rx_bit_overhead; // R4 R5
			end
		end
	end

	// Payload clock: one pulse per update, so 1060 per frame in nibble mode
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pclk_q     <= 1'b0;
			high_cnt_q <= '0;
		end else if (out_update) begin
			pclk_q     <= 1'b1; // R7
			high_cnt_q <= nibble_mode_q ? HIGH_W'(NIB_HIGH_CYC - 1) // R8
				: HIGH_W'(SER_HIGH_CYC - 1);
		end else if (high_cnt_q != '0) begin
			high_cnt_q <= high_cnt_q - 1'b1;
		end else begin
			pclk_q <= 1'b0;
		end
	end

	// Terminal equipment samples all of these on the clock's rise
	assign o_rx_payload_clock      = pclk_q; // R2 R10
	assign o_rx_serial_payload_out = ser_q;
	assign o_rx_payload_nibble     = nib_q;
	assign o_rx_frame_start_marker = frame_q;
	assign o_rx_overhead_marker    = ovh_q;
endmodule : e3_rx_out_irq

// ==== test/e3_rx_out_irq_asserts.sv ====
// Checker for the receive payload port and register read path.
// Sees only the top module's ports; bound in below.
`timescale 1ns/1ps
module e3_rx_out_irq_asserts
	import e3_rx_pkg::*;
(
	// Clock and reset
	input wire logic       i_clk,
	input wire logic       i_sys_rst,
	// Watched ports
	input wire logic [7:0] i_addr,
	input wire logic       i_rd_en,
	input wire logic [7:0] o_rd_data,
	input wire logic       i_rx_bit_valid,
	input wire logic       i_rx_bit_overhead,
	input wire logic       i_line_sig_loss_in,
	input wire logic       o_rx_payload_clock,
	input wire logic       o_rx_serial_payload_out,
	input wire logic [3:0] o_rx_payload_nibble,
	input wire logic       o_rx_frame_start_marker,
	input wire logic       o_rx_overhead_marker
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// Outputs may only move with a payload clock rise
	ser_on_clk_a: assert property ($changed(o_rx_serial_payload_out) |-> $rose(o_rx_payload_clock))
		else $error("serial data moved without clock rise");
	nib_on_clk_a: assert property ($changed(o_rx_payload_nibble) |-> $rose(o_rx_payload_clock))
		else $error("nibble moved without clock rise");
	frame_on_clk_a: assert property ($changed(o_rx_frame_start_marker) |-> $rose(o_rx_payload_clock))
		else $error("frame marker moved without clock rise");
	oh_on_clk_a: assert property ($changed(o_rx_overhead_marker) |-> $rose(o_rx_payload_clock))
		else $error("overhead marker moved without clock rise");
	// Each clock pulse answers one framer bit; marker rise needs an overhead bit
	clk_cause_a: assert property ($rose(o_rx_payload_clock) |-> $past(i_rx_bit_valid))
		else $error("payload clock rose without a bit");
	oh_cause_a: assert property ($rose(o_rx_overhead_marker) |-> $past(i_rx_bit_valid & i_rx_bit_overhead))
		else $error("overhead marker without overhead bit");
	// High time is 4 cycles serial, 8 cycles nibble
	clk_high_a: assert property ($rose(o_rx_payload_clock) |-> o_rx_payload_clock[*4] ##1
		(!o_rx_payload_clock or o_rx_payload_clock[*4] ##1 !o_rx_payload_clock))
		else $error("payload clock high time wrong");
	rd_idle_a: assert property (!$past(i_rd_en) |-> o_rd_data == 8'h00)
		else $error("read data outside read slot");
	ro_bits_a: assert property ($past(i_rd_en) && $past(i_addr) == BLOCK_IRQ_ENABLE_ADDR
		|-> (o_rd_data & ~BLOCK_IRQ_ENABLE_MASK) == 8'h00)
		else $error("reserved enable bits read nonzero");
	los_pin_a: assert property ((i_line_sig_loss_in[*6] ##0 (i_rd_en && i_addr == RX_CFG_STATUS_2_ADDR))
		|=> o_rd_data[LOS_STATE_BIT])
		else $error("loss state low while loss input high");
endmodule : e3_rx_out_irq_asserts

bind e3_rx_out_irq e3_rx_out_irq_asserts u_e3_rx_out_irq_asserts (.i_clk, .i_sys_rst, .i_addr, .i_rd_en,
	.o_rd_data, .i_rx_bit_valid, .i_rx_bit_overhead, .i_line_sig_loss_in, .o_rx_payload_clock,
	.o_rx_serial_payload_out, .o_rx_payload_nibble, .o_rx_frame_start_marker, .o_rx_overhead_marker);

// ==== test/te_rx_model.sv ====
// Terminal equipment on the receive payload port.
// Assumes the bench tells it the port mode.
`timescale 1ns/1ps
module te_rx_model (
	// Port pins
	input  wire logic       i_pclk,
	input  wire logic       i_ser,
	input  wire logic [3:0] i_nib,
	input  wire logic       i_frame,
	input  wire logic       i_oh,
	input  wire logic       i_nib_mode,
	// What it received
	output logic      [7:0] o_pay,
	output logic      [3:0] o_nib,
	output logic      [7:0] o_frames
);
	logic [7:0] pay_q    = 8'h00;
	logic [3:0] nib_q    = 4'h0;
	logic [7:0] frames_q = 8'h00;
	// Data and markers sampled together on each rise; overhead bits dropped.
	// They launch with the rise itself, so they are read just after it settles
	always @(posedge i_pclk) begin
		#1;
		if (i_frame) frames_q <= frames_q + 8'h01;
		if (i_nib_mode) nib_q <= i_nib;
		else if (!i_oh) pay_q <= {pay_q[6:0], i_ser};
	end
	assign o_pay    = pay_q;
	assign o_nib    = nib_q;
	assign o_frames = frames_q;
endmodule : te_rx_model

// ==== test/e3_rx_out_irq_tb.sv ====
// Testbench for the receive payload port and receive interrupts.
// Drives framer, line and register inputs; terminal model sits on the port.
`timescale 1ns/1ps
module e3_rx_out_irq_tb;
	import e3_rx_pkg::*;
	logic i_clk = 0, i_sys_rst = 1, i_wr_en = 0, i_rd_en = 0, i_line_clk = 0, nib_mode = 0;
	logic i_rx_bit_valid = 0, i_rx_bit = 0, i_rx_bit_overhead = 0, i_rx_bit_first = 0;
	logic i_line_positive_rail_in = 1, i_line_negative_rail_in = 0, i_line_sig_loss_in = 0;
	logic [7:0] i_addr = 0, i_wr_data = 0, o_rd_data, te_pay, te_frames, d;
	logic o_rx_payload_clock, o_rx_serial_payload_out, o_rx_frame_start_marker, o_rx_overhead_marker, o_irq_n;
	logic [3:0] o_rx_payload_nibble, te_nib;
	logic [4:0] i_cond_change = 0;
	logic [6:0] i_event = 0;
	logic [2:0] i_cond_state = 0;
	logic [9:0] pat = 10'h2CE;
	int err_count = 0, n_tests = 0, pclk_rises = 0, base = 0;
	e3_rx_out_irq u_e3_rx_out_irq (.i_clk, .i_sys_rst, .i_addr, .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data,
		.i_rx_bit_valid, .i_rx_bit, .i_rx_bit_overhead, .i_rx_bit_first, .i_cond_change, .i_event,
		.i_cond_state, .i_line_clk, .i_line_positive_rail_in, .i_line_negative_rail_in, .i_line_sig_loss_in,
		.o_rx_payload_clock, .o_rx_serial_payload_out, .o_rx_payload_nibble, .o_rx_frame_start_marker,
		.o_rx_overhead_marker, .o_irq_n);
	te_rx_model u_te_rx_model (.i_pclk(o_rx_payload_clock), .i_ser(o_rx_serial_payload_out),
		.i_nib(o_rx_payload_nibble), .i_frame(o_rx_frame_start_marker), .i_oh(o_rx_overhead_marker),
		.i_nib_mode(nib_mode), .o_pay(te_pay), .o_nib(te_nib), .o_frames(te_frames));
	// Payload clock pulses, one per serial bit or per nibble
	always @(posedge o_rx_payload_clock) pclk_rises++;
	// Core clock and an unrelated line clock
	initial forever #10 i_clk = ~i_clk;
	initial begin
		#7;
		forever #80 i_line_clk = ~i_line_clk;
	end
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge i_clk);
		i_wr_en <= 1;
		i_addr <= a;
		i_wr_data <= v;
		@(posedge i_clk);
		i_wr_en <= 0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge i_clk);
		i_rd_en <= 1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd_en <= 0;
		#1 v = o_rd_data;
	endtask : rd
	// One framer bit every 8 cycles, as a line bit would arrive
	task send(input logic b, input logic oh, input logic first);
		@(posedge i_clk);
		i_rx_bit_valid <= 1;
		i_rx_bit <= b;
		i_rx_bit_overhead <= oh;
		i_rx_bit_first <= first;
		@(posedge i_clk);
		i_rx_bit_valid <= 0;
		repeat (6) @(posedge i_clk);
	endtask : send
	// Hold the rails for n line bits, then let the syncs settle
	task line_run(input logic [1:0] rails, input int n);
		@(posedge i_clk);
		{i_line_positive_rail_in, i_line_negative_rail_in} <= rails;
		repeat (n) @(posedge i_line_clk);
		repeat (10) @(posedge i_clk);
	endtask : line_run
	task report_and_stop;
		$display("comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop
	// Hang guard, well past the thousand or so cycles the tests need
	initial begin
		repeat (20000) @(posedge i_clk);
		err_count++;
		$display("watchdog expired");
		report_and_stop();
	end
	initial begin
		repeat (10) @(posedge i_clk);
		i_sys_rst <= 0;
		rd(BLOCK_IRQ_ENABLE_ADDR, d); chk("block enable reset", 8'h00, d);
		rd(RX_IRQ_ENABLE_1_ADDR, d); chk("source enable reset", 8'h00, d);
		wr(BLOCK_IRQ_ENABLE_ADDR, 8'hFF);
		rd(BLOCK_IRQ_ENABLE_ADDR, d); chk("block enable", 8'h83, d);
		wr(RX_IRQ_ENABLE_1_ADDR, 8'hFF);
		rd(RX_IRQ_ENABLE_1_ADDR, d); chk("source enable", 8'h1F, d);
		rd(8'h30, d); chk("unmapped read", 8'h00, d);
		wr(RX_IRQ_ENABLE_1_ADDR, 8'h00);
		$display("register test done");
		// Serial: frame start then two overhead bits
		base = pclk_rises;
		for (int i = 0; i < 10; i++) send(pat[9-i], i == 1 || i == 2, i == 0);
		repeat (8) @(posedge i_clk);
		chk("serial clock pulses", 8'h0A, 8'(pclk_rises - base));
		chk("serial payload", {pat[9], pat[6:0]}, te_pay);
		chk("serial frames", 8'h01, te_frames);
		$display("serial test done");
		// Nibble: one overhead bit skipped, two nibbles out
		wr(RX_OUT_CONFIG_ADDR, 8'h01);
		nib_mode <= 1;
		base = pclk_rises;
		for (int i = 0; i < 9; i++) send(pat[9-i], i == 2, i == 0);
		repeat (8) @(posedge i_clk);
		chk("nibble clock pulses", 8'h02, 8'(pclk_rises - base));
		chk("last nibble", {4'h0, pat[4:1]}, {4'h0, te_nib});
		chk("nibble frames", 8'h02, te_frames);
		$display("nibble test done");
		// Loss of signal from a zero run, then cleared with the negative rail only
		wr(RX_IRQ_ENABLE_1_ADDR, 8'h02);
		line_run(2'b00, 40);
		chk("irq on declare", 8'h00, {7'h0, o_irq_n});
		rd(RX_IRQ_STATUS_1_ADDR, d); chk("status on declare", 8'h02, d & 8'h02);
		rd(RX_CFG_STATUS_2_ADDR, d); chk("loss state set", 8'h10, d & 8'h10);
		rd(RX_IRQ_STATUS_1_ADDR, d); chk("status cleared", 8'h00, d);
		chk("irq released", 8'h01, {7'h0, o_irq_n});
		line_run(2'b01, 40);
		chk("irq on clear", 8'h00, {7'h0, o_irq_n});
		rd(RX_CFG_STATUS_2_ADDR, d); chk("loss state clear", 8'h00, d & 8'h10);
		rd(RX_IRQ_STATUS_1_ADDR, d); chk("status on clear", 8'h02, d & 8'h02);
		$display("line loss test done");
		// Loss input with the source disabled, then with the block disabled
		wr(RX_IRQ_ENABLE_1_ADDR, 8'h00);
		i_line_sig_loss_in <= 1;
		repeat (10) @(posedge i_clk);
		chk("irq source off", 8'h01, {7'h0, o_irq_n});
		rd(RX_CFG_STATUS_2_ADDR, d); chk("pin loss state", 8'h10, d & 8'h10);
		rd(RX_IRQ_STATUS_1_ADDR, d); chk("status source off", 8'h00, d);
		wr(BLOCK_IRQ_ENABLE_ADDR, 8'h00);
		wr(RX_IRQ_ENABLE_1_ADDR, 8'h02);
		i_line_sig_loss_in <= 0;
		repeat (10) @(posedge i_clk);
		chk("irq block off", 8'h01, {7'h0, o_irq_n});
		rd(RX_IRQ_STATUS_1_ADDR, d); chk("status block off", 8'h02, d & 8'h02);
		$display("enable test done");
		// Framer sources and condition levels, then the block enable alone
		wr(RX_IRQ_ENABLE_2_ADDR, 8'hFF);
		rd(RX_IRQ_ENABLE_2_ADDR, d); chk("source enable 2", 8'h7F, d);
		wr(RX_IRQ_ENABLE_1_ADDR, 8'h1F);
		i_event <= 7'h41;
		i_cond_change <= 5'h1F;
		i_cond_state <= 3'h7;
		@(posedge i_clk);
		i_event <= 7'h00;
		i_cond_change <= 5'h00;
		rd(RX_IRQ_STATUS_1_ADDR, d); chk("status framer sources", 8'h1D, d);
		rd(RX_CFG_STATUS_2_ADDR, d); chk("condition levels", 8'h68, d & 8'h68);
		chk("irq block still off", 8'h01, {7'h0, o_irq_n});
		wr(BLOCK_IRQ_ENABLE_ADDR, 8'h80);
		repeat (2) @(posedge i_clk);
		chk("irq block on", 8'h00, {7'h0, o_irq_n});
		rd(RX_IRQ_STATUS_2_ADDR, d); chk("status event sources", 8'h41, d);
		repeat (2) @(posedge i_clk);
		chk("irq after clear", 8'h01, {7'h0, o_irq_n});
		$display("source test done");
		report_and_stop();
	end
endmodule : e3_rx_out_irq_tb
